// file: sep_serial_port.sv
`timescale 1ns/1ns
module sep_serial_port #(
  parameter int WRITE_CYCLES   = sep_pkg::WRITE_CYCLES,
  parameter int POWERUP_CYCLES = sep_pkg::POWERUP_CYCLES,
  parameter int MEM_BYTES      = 4096
) (
  // Housekeeping clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Serial link pins
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              si,
  input  wire logic              hold_n,
  input  wire logic              wp_n,
  output logic                   so_o,
  output logic                   so_oe_n,
  // Observation
  output sep_pkg::sep_stat_t     status,
  output logic                   ready
);
  typedef enum {ST_PWRUP, ST_IDLE, ST_PROG, ST_WAIT} sep_state_t;

  logic [7:0]               mem [MEM_BYTES];
  logic [7:0]               page_buf [sep_pkg::PAGE_BYTES];
  logic                     rst_q;
  // ----------------------------------------------------------------
  // Link side: frame decoder on the serial clock
  // ----------------------------------------------------------------
  logic [2:0]               bit_r, bit_nxt;
  logic [1:0]               byte_r, byte_nxt;
  logic [6:0]               shift_r, shift_nxt;
  sep_pkg::sep_cmd_t        cmd_r, cmd_nxt, dec_cmd;
  logic [15:0]              addr_r, addr_nxt;
  logic [7:0]               out_r, out_nxt;
  logic [7:0]               rx_byte, stat_byte;
  logic                     byte_done, so_r, so_nxt, drive;
  sep_pkg::sep_stat_t       stat_k;
  logic [15:0]              full_addr;

  assign rx_byte   = {shift_r, si};
  assign byte_done = hold_n && (bit_r == 3'h7);
  assign full_addr = {addr_r[15:8], rx_byte};
  assign stat_byte = {stat_k.protect_pin_enable, 3'h0, stat_k.block_guard_high,
                      stat_k.block_guard_low, stat_k.write_latch_bit, stat_k.busy};

  // Command decode, refusing all but status read while busy
  always_comb
  begin
    unique case (rx_byte)
      sep_pkg::OP_WREN:  dec_cmd = sep_pkg::CMD_WREN;
      sep_pkg::OP_WRDI:  dec_cmd = sep_pkg::CMD_WRDI;
      sep_pkg::OP_STATUS_READ_CMD:  dec_cmd = sep_pkg::CMD_STATUS_READ_CMD;
      sep_pkg::OP_WRSR:  dec_cmd = sep_pkg::CMD_WRSR;
      sep_pkg::OP_READ:  dec_cmd = sep_pkg::CMD_READ;
      sep_pkg::OP_WRITE: dec_cmd = sep_pkg::CMD_WRITE;
      default:           dec_cmd = sep_pkg::CMD_NONE;
    endcase
    if (stat_k.busy && dec_cmd != sep_pkg::CMD_STATUS_READ_CMD)
      dec_cmd = sep_pkg::CMD_NONE;
  end

  // Bit/byte counting and read data preparation; pause freezes everything
  always_comb
  begin
    bit_nxt   = bit_r;
    byte_nxt  = byte_r;
    shift_nxt = shift_r;
    cmd_nxt   = cmd_r;
    addr_nxt  = addr_r;
    out_nxt   = out_r;
    if (hold_n)
    begin
      bit_nxt   = bit_r + 3'h1;
      shift_nxt = rx_byte[6:0];
    end
    if (byte_done)
    begin
      if (byte_r != 2'h3)
        byte_nxt = byte_r + 2'h1;
      unique case (byte_r)
        2'h0:
        begin
          cmd_nxt = dec_cmd;
          out_nxt = stat_byte;
        end
        2'h1: addr_nxt[15:8] = rx_byte;
        2'h2:
        begin
          addr_nxt = full_addr;
          if (cmd_r == sep_pkg::CMD_READ)
          begin
            out_nxt  = mem[full_addr[sep_pkg::ADDR_BITS-1:0]];
            addr_nxt = full_addr + 16'h0001;
          end
        end
        2'h3:
        begin
          if (cmd_r == sep_pkg::CMD_READ)
          begin
            out_nxt  = mem[addr_r[sep_pkg::ADDR_BITS-1:0]];
            addr_nxt = addr_r + 16'h0001;
          end
          else if (cmd_r == sep_pkg::CMD_WRITE)
            addr_nxt[sep_pkg::PAGE_BITS-1:0] = addr_r[sep_pkg::PAGE_BITS-1:0] + 5'h01;
          else
            out_nxt = stat_byte;
        end
      endcase
      if (cmd_r == sep_pkg::CMD_STATUS_READ_CMD)
        out_nxt = stat_byte;
    end
  end

  // Select high returns the decoder to idle at once
  always_ff @(posedge sck or posedge cs_n)
  begin
    if (cs_n)
    begin
      bit_r   <= 3'h0;
      byte_r  <= 2'h0;
      shift_r <= 7'h00;
      cmd_r   <= sep_pkg::CMD_NONE;
      addr_r  <= 16'h0000;
      out_r   <= 8'h00;
    end
    else
    begin
      bit_r   <= bit_nxt;
      byte_r  <= byte_nxt;
      shift_r <= shift_nxt;
      cmd_r   <= cmd_nxt;
      addr_r  <= addr_nxt;
      out_r   <= out_nxt;
    end
  end

  // Output bit launched on the falling edge, MSB first
  assign so_nxt = hold_n ? out_r[~bit_r] : so_r;
  always_ff @(negedge sck or posedge cs_n)
  begin
    if (cs_n)
      so_r <= 1'b0;
    else
      so_r <= so_nxt;
  end

  // Drive only while a read phase is running and not paused
  assign drive   = (cmd_r == sep_pkg::CMD_STATUS_READ_CMD) ||
                   (cmd_r == sep_pkg::CMD_READ && byte_r == 2'h3);
  assign so_oe_n = cs_n | ~hold_n | ~drive;
  assign so_o    = so_r;
  // ----------------------------------------------------------------
  // Link side: frame result handed to the housekeeping domain
  // ----------------------------------------------------------------
  // These survive select rising; the toggle marks a new decoded command
  logic                     tog_r, tog_nxt;
  sep_pkg::sep_cmd_t        res_cmd_r, res_cmd_nxt;
  logic [7:0]               res_dat_r, res_dat_nxt;
  logic [sep_pkg::ADDR_BITS-1:sep_pkg::PAGE_BITS] res_page_r, res_page_nxt;
  logic [sep_pkg::PAGE_BYTES-1:0] mask_r, mask_nxt;
  logic                     data_byte;

  assign data_byte = byte_done &&
                     ((cmd_r == sep_pkg::CMD_WRSR && byte_r == 2'h1) ||
                      (cmd_r == sep_pkg::CMD_WRITE && byte_r == 2'h3));

  always_comb
  begin
    tog_nxt      = tog_r;
    res_cmd_nxt  = res_cmd_r;
    res_dat_nxt  = res_dat_r;
    res_page_nxt = res_page_r;
    mask_nxt     = mask_r;
    if (byte_done && byte_r == 2'h0 && dec_cmd != sep_pkg::CMD_NONE)
    begin
      tog_nxt     = ~tog_r;
      res_cmd_nxt = dec_cmd;
      mask_nxt    = '0;
    end
    if (data_byte)
    begin
      res_dat_nxt  = rx_byte;
      res_page_nxt = addr_r[sep_pkg::ADDR_BITS-1:sep_pkg::PAGE_BITS];
      mask_nxt[addr_r[sep_pkg::PAGE_BITS-1:0]] = 1'b1;
    end
  end

  always_ff @(posedge sck or posedge rst_q)
  begin
    if (rst_q)
    begin
      tog_r      <= 1'b0;
      res_cmd_r  <= sep_pkg::CMD_NONE;
      res_dat_r  <= 8'h00;
      res_page_r <= '0;
      mask_r     <= '0;
    end
    else
    begin
      tog_r      <= tog_nxt;
      res_cmd_r  <= res_cmd_nxt;
      res_dat_r  <= res_dat_nxt;
      res_page_r <= res_page_nxt;
      mask_r     <= mask_nxt;
    end
  end

  // Page buffer holds loaded bytes; later bytes overwrite on roll-over
  always_ff @(posedge sck)
  begin
    if (data_byte && cmd_r == sep_pkg::CMD_WRITE)
      page_buf[addr_r[sep_pkg::PAGE_BITS-1:0]] <= rx_byte;
  end

  sep_sync #(.W(5)) u_stat_sync (
    .dclk (sck),
    .clr  (rst_q),
    .din  (status),
    .dout (stat_k)
  );
  // ----------------------------------------------------------------
  // Housekeeping side: status register and write cycle timer
  // ----------------------------------------------------------------
  logic                     cs_s, wp_s, tog_s;
  logic                     cs_prev_r, seen_r, seen_nxt;
  sep_state_t               st_r, st_nxt;
  sep_pkg::sep_stat_t       stat_r, stat_nxt;
  logic [19:0]              cnt_r, cnt_nxt;
  logic [sep_pkg::PAGE_BITS-1:0] idx_r, idx_nxt;
  logic [sep_pkg::ADDR_BITS-1:0] wr_addr;
  logic                     wr_en, guarded, frame_end;

  sep_sync #(.W(3)) u_pin_sync (
    .dclk (clk),
    .clr  (rst_q),
    .din  ({cs_n, wp_n, tog_r}),
    .dout ({cs_s, wp_s, tog_s})
  );

  assign frame_end = cs_s && !cs_prev_r && (tog_s != seen_r);
  assign wr_addr   = {res_page_r, idx_r};
  // Block guard bits select the protected tail of the array
  always_comb
  begin
    unique case ({stat_r.block_guard_high, stat_r.block_guard_low})
      2'b00: guarded = 1'b0;
      2'b01: guarded = wr_addr[11:10] == 2'b11;
      2'b10: guarded = wr_addr[11];
      2'b11: guarded = 1'b1;
    endcase
  end
  assign wr_en = (st_r == ST_PROG) && mask_r[idx_r] && !guarded;

  // Commands take effect when select rises, as the array needs a whole frame
  always_comb
  begin
    st_nxt   = st_r;
    stat_nxt = stat_r;
    cnt_nxt  = cnt_r;
    idx_nxt  = idx_r;
    seen_nxt = frame_end ? tog_s : seen_r;
    unique case (st_r)
      ST_PWRUP:
      begin
        cnt_nxt = cnt_r + 20'h00001;
        if (cnt_r == 20'(POWERUP_CYCLES - 1))
          st_nxt = ST_IDLE;
      end
      ST_IDLE:
      begin
        // Head start covers the select synchroniser, so the cycle ends in time
        cnt_nxt = 20'(sep_pkg::CS_SEEN_CYCLES);
        idx_nxt = '0;
        if (frame_end)
        begin
          unique case (res_cmd_r)
            sep_pkg::CMD_WREN: stat_nxt.write_latch_bit = 1'b1;
            sep_pkg::CMD_WRDI: stat_nxt.write_latch_bit = 1'b0;
            sep_pkg::CMD_WRSR:
              // Pin high never refuses; pin low refuses when enabled
              if (stat_r.write_latch_bit && |mask_r &&
                  !(stat_r.protect_pin_enable && !wp_s))
              begin
                stat_nxt.protect_pin_enable = res_dat_r[sep_pkg::ST_PROTECT_PIN_ENABLE_BIT];
                stat_nxt.block_guard_high   = res_dat_r[sep_pkg::ST_BP_HI];
                stat_nxt.block_guard_low    = res_dat_r[sep_pkg::ST_BP_LO];
                stat_nxt.busy               = 1'b1;
                st_nxt                      = ST_WAIT;
              end
            sep_pkg::CMD_WRITE:
              if (stat_r.write_latch_bit && |mask_r)
              begin
                stat_nxt.busy = 1'b1;
                st_nxt        = ST_PROG;
              end
            default: ;
          endcase
        end
      end
      ST_PROG:
      begin
        idx_nxt = idx_r + 5'h01;
        cnt_nxt = cnt_r + 20'h00001;
        if (idx_r == 5'(sep_pkg::PAGE_BYTES - 1))
          st_nxt = ST_WAIT;
      end
      ST_WAIT:
      begin
        // Runs regardless of select, so standby never cuts it short
        cnt_nxt = cnt_r + 20'h00001;
        if (cnt_r >= 20'(WRITE_CYCLES - 1))
        begin
          stat_nxt.busy            = 1'b0;
          stat_nxt.write_latch_bit = 1'b0;
          st_nxt                   = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    rst_q <= rst;
    if (rst)
    begin
      st_r      <= ST_PWRUP;
      stat_r    <= sep_pkg::STAT_RESET;
      cnt_r     <= 20'h00000;
      idx_r     <= '0;
      cs_prev_r <= 1'b1;
      seen_r    <= 1'b0;
    end
    else
    begin
      st_r      <= st_nxt;
      stat_r    <= stat_nxt;
      cnt_r     <= cnt_nxt;
      idx_r     <= idx_nxt;
      cs_prev_r <= cs_s;
      seen_r    <= seen_nxt;
    end
  end

  // Array programming, one loaded byte per clock
  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_addr] <= page_buf[idx_r];
  end

  assign status = stat_r;
  assign ready  = (st_r != sep_state_t'(ST_PWRUP));
endmodule

// file: sep_pkg.sv
// ----------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------
package sep_pkg;
  // Clock rate of the housekeeping domain
  localparam int CLK_KHZ        = 100000;
  // Internal write time and power-up delay, in ms
  localparam int WRITE_TIME_MS  = 5;
  localparam int POWERUP_MS     = 1;
  // Longest time in whole cycles, ms times kHz with no rounding
  localparam int WRITE_CYCLES   = WRITE_TIME_MS * CLK_KHZ;
  localparam int POWERUP_CYCLES = POWERUP_MS * CLK_KHZ;
  // Clocks a select rise needs to be seen; the write timer starts this far on
  localparam int CS_SEEN_CYCLES = 6;
  // Command codes
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_STATUS_READ_CMD  = 8'h05;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_READ  = 8'h03;
  localparam logic [7:0] OP_WRITE = 8'h02;
  // Status byte field positions
  localparam int ST_PROTECT_PIN_ENABLE_BIT = 7;
  localparam int ST_BP_HI    = 3;
  localparam int ST_BP_LO    = 2;
  localparam int ST_WEL_BIT  = 1;
  localparam int ST_BUSY_BIT = 0;
  // Array geometry
  localparam int ADDR_BITS   = 12;
  localparam int PAGE_BYTES  = 32;
  localparam int PAGE_BITS   = 5;

  typedef enum logic [2:0] {
    CMD_NONE, CMD_WREN, CMD_WRDI, CMD_STATUS_READ_CMD, CMD_WRSR, CMD_READ, CMD_WRITE
  } sep_cmd_t;

  typedef struct packed {
    logic       protect_pin_enable;
    logic       block_guard_high;
    logic       block_guard_low;
    logic       write_latch_bit;
    logic       busy;
  } sep_stat_t;

  localparam sep_stat_t STAT_RESET = '0;
endpackage

// file: sep_sync.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Three-stage synchroniser with agreement filter
// ----------------------------------------------------------------
module sep_sync #(
  parameter int W = 1
) (
  // Destination clock and async clear
  input  wire logic         dclk,
  input  wire logic         clr,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  // Only take a change once the last two stages agree
  always_comb
  begin
    out_nxt = out_r;
    for (int i = 0; i < W; i++)
    begin
      if (s2_r[i] == s3_r[i])
        out_nxt[i] = s3_r[i];
    end
  end

  always_ff @(posedge dclk or posedge clr)
  begin
    if (clr)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end
    else
    begin
      s1_r  <= din;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign dout = out_r;
endmodule

// file: sep_serial_port_sva.sv
`timescale 1ns/1ns
// --------
// Port checker for the serial front end
// --------
module sep_serial_port_sva #(
  parameter int WRITE_CYCLES = sep_pkg::WRITE_CYCLES
) (
  // Housekeeping clock and reset
  input wire logic               clk,
  input wire logic               rst,
  // Serial link pins
  input wire logic               sck,
  input wire logic               cs_n,
  input wire logic               si,
  input wire logic               hold_n,
  input wire logic               wp_n,
  input wire logic               so_o,
  input wire logic               so_oe_n,
  // Observation
  input wire sep_pkg::sep_stat_t status,
  input wire logic               ready
);
  int   busy_cnt_r;
  int   busy_cnt_nxt;
  int   wplo_cnt_r;
  int   wplo_cnt_nxt;
  logic so_rise_r;
  // Run lengths; the pin count saturates so it never wraps
  always_comb
  begin
    busy_cnt_nxt = status.busy ? busy_cnt_r + 1 : 0;
    wplo_cnt_nxt = wp_n ? 0 : ((wplo_cnt_r < 64) ? wplo_cnt_r + 1 : 64);
  end
  always_ff @(posedge clk)
  begin
    busy_cnt_r <= rst ? 0 : busy_cnt_nxt;
    wplo_cnt_r <= rst ? 0 : wplo_cnt_nxt;
  end
  // Output bit seen at the rising edge must still stand at the falling one
  always_ff @(posedge sck)
  begin
    so_rise_r <= so_o;
  end
  // Output enable and bit timing
  chk_select_float: assert property (@(posedge clk) disable iff (rst) cs_n |-> so_oe_n)
    else $error("output enabled while deselected");
  chk_pause_float: assert property (@(posedge clk) disable iff (rst) !hold_n |-> so_oe_n)
    else $error("output enabled during pause");
  chk_so_falling: assert property (@(negedge sck) disable iff (rst) !so_oe_n |-> so_o == so_rise_r)
    else $error("output bit moved on a rising edge");
  // Write cycle and protection
  chk_busy_bound: assert property (@(posedge clk) disable iff (rst) busy_cnt_r <= WRITE_CYCLES)
    else $error("write cycle overran");
  chk_busy_no_latch: assert property (@(posedge clk) disable iff (rst) status.busy |=> !$rose(status.write_latch_bit))
    else $error("command taken while busy");
  chk_guard_lock: assert property (@(posedge clk) disable iff (rst)
    status.protect_pin_enable && wplo_cnt_r == 64 |=> $stable({status.protect_pin_enable,
    status.block_guard_high, status.block_guard_low}))
    else $error("status written while pin protected");
  // Power-up behaviour
  chk_reset_quiet: assert property (@(posedge clk) disable iff (rst) $fell(rst) |-> (!ready && status == '0)[*8])
    else $error("ready or status early after reset");
  chk_ready_keep: assert property (@(posedge clk) disable iff (rst) ready |=> ready)
    else $error("ready dropped");
  cov_busy: cover property (@(posedge clk) $rose(status.busy));
  cov_pause: cover property (@(posedge clk) !cs_n && !hold_n);
  cov_latch: cover property (@(posedge clk) $rose(status.write_latch_bit));
endmodule
bind sep_serial_port sep_serial_port_sva #(
  .WRITE_CYCLES(WRITE_CYCLES)
) u_chk (
  .clk     (clk),
  .rst     (rst),
  .sck     (sck),
  .cs_n    (cs_n),
  .si      (si),
  .hold_n  (hold_n),
  .wp_n    (wp_n),
  .so_o    (so_o),
  .so_oe_n (so_oe_n),
  .status  (status),
  .ready   (ready)
);

// file: sep_host_model.sv
`timescale 1ns/1ns
// --------
// Host end of the link, mode 0, 15 ns clock only inside frames
// --------
module sep_host_model (
  // Link pins toward the device
  output logic      sck,
  output logic      cs_n,
  output logic      si,
  output logic      hold_n,
  input  wire logic so_o,
  input  wire logic so_oe_n
);
  logic so_last;
  // Idle: clock low, deselected, pause released
  initial
  begin
    sck     = 1'b0;
    cs_n    = 1'b1;
    si      = 1'b0;
    hold_n  = 1'b1;
    so_last = 1'b0;
  end
  // Frame opens with a falling select
  task automatic start();
    #10 cs_n = 1'b0;
    #10;
  endtask
  // Long gap so the housekeeping side sees the rising select
  task automatic stop();
    #10 cs_n = 1'b1;
    #130;
  endtask
  // One byte MSB first; a floating line reads as the inverse of the last bit
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      si = tx[i];
      #8;
      so_last = so_oe_n ? ~so_last : so_o;
      rx[i] = so_last;
      sck = 1'b1;
      #7 sck = 1'b0;
    end
  endtask
  // Pause moves only while the clock is low, clear of its falling edge
  task automatic pause(input logic lvl);
    #5 hold_n = lvl;
    #10;
  endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ns
// --------
// Serial front end bench
// --------
module testbench;
  localparam int WC = 200;
  localparam int PU = 50;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic               wp_n = 1'b1;
  logic               sck, cs_n, si, hold_n, so_o, so_oe_n, ready;
  sep_pkg::sep_stat_t status;
  logic [7:0]         s;
  int                 errors = 0;
  int                 num_checks = 0;
  // 100 MHz housekeeping clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Short counts keep the run brief
  sep_serial_port #(.WRITE_CYCLES(WC), .POWERUP_CYCLES(PU)) dut (.clk(clk), .rst(rst), .sck(sck),
    .cs_n(cs_n), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so_o(so_o), .so_oe_n(so_oe_n),
    .status(status), .ready(ready));
  sep_host_model host (.sck(sck), .cs_n(cs_n), .si(si), .hold_n(hold_n), .so_o(so_o), .so_oe_n(so_oe_n));
  // Counts, verdict, end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Byte compare
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One-byte and two-byte frames
  task automatic cmd(input logic [7:0] op);
    logic [7:0] d;
    host.start();
    host.xfer(op, d);
    host.stop();
  endtask
  task automatic cmd2(input logic [7:0] op, input logic [7:0] v, output logic [7:0] r);
    logic [7:0] d;
    host.start();
    host.xfer(op, d);
    host.xfer(v, r);
    host.stop();
  endtask
  // Bounded wait for the write cycle to end
  task automatic wait_idle();
    int n;
    n = 0;
    while (status.busy !== 1'b0 && n <= WC + 20)
    begin
      @(posedge clk);
      n++;
    end
    chk8(8'(n <= WC), 8'h01, "write time");
    if (n > WC + 20)
      stop_test();
  endtask
  // Main sequence
  initial
  begin
    logic [7:0] d;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    repeat (PU + 20) if (ready !== 1'b1) @(posedge clk);
    chk8({7'h00, ready}, 8'h01, "ready");
    if (ready !== 1'b1)
      stop_test();
    cmd2(8'h05, 8'h00, s);
    chk8(s, 8'h00, "status after reset");
    chk8({7'h00, so_oe_n}, 8'h01, "float when idle");
    cmd(8'h06);
    cmd2(8'h05, 8'h00, s);
    chk8(s, 8'h02, "latch set");
    cmd(8'h04);
    cmd2(8'h05, 8'h00, s);
    chk8(s, 8'h00, "latch cleared");
    cmd(8'h06);
    cmd(8'h84);
    cmd2(8'h05, 8'h00, s);
    chk8(s, 8'h02, "unknown ignored");
    $display("test commands done");
    // Status write lands bits 7,3,2 at once; all but status read dropped while busy
    cmd2(8'h01, 8'hFC, d);
    cmd2(8'h05, 8'h00, s);
    chk8(s, 8'h8F, "busy read");
    cmd(8'h06);
    cmd(8'h04);
    cmd2(8'h05, 8'h00, s);
    chk8(s, 8'h8F, "ignored while busy");
    wait_idle();
    cmd2(8'h05, 8'h00, s);
    chk8(s, 8'h8C, "status written");
    $display("test status write done");
    // Pin low with enable set refuses, pin high allows
    @(posedge clk);
    wp_n <= 1'b0;
    cmd(8'h06);
    cmd2(8'h01, 8'h00, d);
    repeat (50) @(posedge clk);
    cmd2(8'h05, 8'h00, s);
    chk8(s & 8'hFD, 8'h8C, "refused write");
    @(posedge clk);
    wp_n <= 1'b1;
    cmd(8'h06);
    cmd2(8'h01, 8'h00, d);
    wait_idle();
    cmd2(8'h05, 8'h00, s);
    chk8(s, 8'h00, "pin high writes");
    $display("test protect done");
    // Page write with junk upper address, read back with a pause
    cmd(8'h06);
    host.start();
    host.xfer(8'h02, d);
    host.xfer(8'hF0, d);
    host.xfer(8'h10, d);
    host.xfer(8'hA5, d);
    host.xfer(8'h3C, d);
    host.stop();
    wait_idle();
    host.start();
    host.xfer(8'h03, d);
    host.xfer(8'h00, d);
    host.xfer(8'h10, d);
    host.xfer(8'h00, s);
    chk8(s, 8'hA5, "first byte");
    host.pause(1'b0);
    chk8({7'h00, so_oe_n}, 8'h01, "float in pause");
    host.xfer(8'hFF, d);
    chk8({7'h00, so_oe_n}, 8'h01, "float while clocked in pause");
    host.pause(1'b1);
    chk8({7'h00, so_oe_n}, 8'h00, "driven after pause");
    host.xfer(8'h00, s);
    chk8(s, 8'h3C, "resumed byte");
    host.stop();
    chk8({7'h00, so_oe_n}, 8'h01, "float after frame");
    $display("test array done");
    stop_test();
  end
endmodule
